// ---- hw/asfbl_uart.sv ----
// Behaviour
// RL1 - line rests high while idle, before any character is sent or received
// RL2 - every character opens with one start bit at logic zero
// RL3 - data bits travel least significant bit first
// RL4 - one stop bit at logic one closes each frame
// RL5 - break is zero for a whole frame or more, sent and recognised
// RL6 - hardware parity generated on transmit, checked and flagged on receive
// RL7 - control bit 4 selects eight or nine data bits; one may be parity
// RL8 - bit timing comes from a 13-bit modulus counter on the peripheral clock
// RL9 - bit rate equals clock over sixteen times the 13-bit divisor
// RL10 - divisor high and low bytes form one value; low write commits
// RL11 - divisor bits always writable; top three bits only in special mode
// RL12 - rate generator off until first enable after reset, and when divisor is zero
// RL13 - loop select detaches receiver from receive pin; source bit picks input
// RL14 - loop source 0 feeds receiver from transmitter, 1 from transmit pin
// RL15 - software enables transmitter and receiver before loop or single wire use
// RL16 - in loop mode with transmit pin direction set, pin carries transmit waveform
// RL17 - loop, direction clear: pin high for source 0, floating for source 1
// RL18 - single wire with pin output returns transmitted signal to receiver
// RL19 - wired-or select makes output pins drive low only, also as general purpose
// RL20 - transmit enable activates transmitter and owns pin; receive enable activates receiver
`timescale 1ns/100ps
`include "asfbl_cfg.svh"

module asfbl_uart (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_mode,
    input wire logic txd_in,
    input wire logic rxd_in,
    output asfbl_pkg::asfbl_pins_t pins
);
    import asfbl_pkg::*;

    asfbl_state_t s;
    asfbl_state_t n;

    logic loop_sel;
    logic wired_or;
    logic fb_sel;
    logic nine;
    logic par_en;
    logic par_odd;
    logic tick;
    logic rx_src;
    logic tx_drive;
    logic tx_val;
    logic rx_drive;
    logic setup;
    logic access;
    logic [3:0] frame_bits;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic asfbl_hit(input logic [11:0] addr, input logic [7:0] idx);
        return addr == {2'b00, idx, 2'b00};
    endfunction

    // mask covering the data field of a character, parity bit included
    function automatic logic [8:0] asfbl_mask(input logic nine_bits);
        return nine_bits ? 9'h1FF : 9'h0FF;
    endfunction

    function automatic logic [10:0] asfbl_frame(input logic [8:0] d, input logic nine_bits,
            input logic pe, input logic odd);
        logic [8:0] bits;
        logic [10:0] f;
        bits = d & asfbl_mask(nine_bits);
        f = 11'h7FF;
        if (pe) begin
            // RL6 RL7
            bits[nine_bits ? 8 : 7] = (^(bits & (asfbl_mask(nine_bits) >> 1))) ^ odd;
        end
        // RL2 RL3 RL4
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < (nine_bits ? 9 : 8)) begin
                f[i + 1] = bits[i];
            end
        end
        return f;
    endfunction

    assign loop_sel = s.ctrl[`ASFBL_LOOP_SELECT];
    assign wired_or = s.ctrl[`ASFBL_WIRED_OR_SELECT];
    assign fb_sel = s.ctrl[`ASFBL_RX_FEEDBACK_SELECT];
    assign nine = s.ctrl[`ASFBL_NINE_BITS];
    assign par_en = s.ctrl[`ASFBL_PARITY_EN];
    assign par_odd = s.ctrl[`ASFBL_PARITY_ODD];
    assign frame_bits = nine ? 4'd9 : 4'd8;
    assign setup = psel && !penable;
    assign access = psel && penable;

    // RL8 RL9 RL12
    assign tick = s.baud_armed && (s.div[12:0] != 13'h0000)
        && (s.baud_cnt == s.div[12:0] - 13'h0001);

    // receiver input: pin in normal mode, internal or transmit pin when looped
    always_comb begin
        if (!loop_sel) begin
            rx_src = s.rxd_sync[1];
        end else if (!fb_sel) begin
            rx_src = s.tx_line; // RL13 RL14
        end else begin
            rx_src = s.txd_sync[1]; // RL14 RL18
        end
    end

    // transmit and receive pin drive
    always_comb begin
        tx_drive = 1'b0;
        tx_val = 1'b1;
        if (!loop_sel) begin
            if (s.tx_enable) begin
                tx_drive = 1'b1; // RL20
                tx_val = s.tx_line;
            end else begin
                tx_drive = s.port[`ASFBL_PORT_DIR_LO + 1];
                tx_val = s.port[1];
            end
        end else if (s.port[`ASFBL_PORT_DIR_LO + 1]) begin
            tx_drive = 1'b1; // RL16
            tx_val = s.tx_line;
        end else if (!fb_sel) begin
            tx_drive = 1'b1; // RL17
            tx_val = 1'b1;
        end
        // receive pin is free for general use when looped or receiver is off
        rx_drive = s.port[`ASFBL_PORT_DIR_LO] && (loop_sel || !s.rx_enable); // RL13
    end

    // open drain drives only low; the pull-up belongs to the board
    always_comb begin
        if (wired_or) begin
            pins.txd_out = 1'b0; // RL19
            pins.txd_oe_n = !(tx_drive && !tx_val);
            pins.rxd_out = 1'b0;
            pins.rxd_oe_n = !(rx_drive && !s.port[0]);
        end else begin
            pins.txd_out = tx_val;
            pins.txd_oe_n = !tx_drive;
            pins.rxd_out = s.port[0];
            pins.rxd_oe_n = !rx_drive;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0000_0000;
        if (asfbl_hit(paddr, `ASFBL_IDX_DIV)) begin
            rd_word[15:0] = s.div;
        end else if (asfbl_hit(paddr, `ASFBL_IDX_CTRL)) begin
            rd_word[7:0] = s.ctrl;
        end else if (asfbl_hit(paddr, `ASFBL_IDX_ENA)) begin
            rd_word[`ASFBL_TX_ENABLE] = s.tx_enable;
            rd_word[`ASFBL_RX_ENABLE] = s.rx_enable;
            rd_word[`ASFBL_SEND_BREAK] = s.send_break;
        end else if (asfbl_hit(paddr, `ASFBL_IDX_STAT)) begin
            rd_word[`ASFBL_ST_TX_READY] = s.tx_ready;
            rd_word[`ASFBL_ST_TX_IDLE] = (s.tx_state == ASFBL_TX_IDLE) && s.tx_ready;
            rd_word[`ASFBL_ST_RX_FULL] = s.rx_full;
            rd_word[`ASFBL_ST_OVERRUN] = s.overrun;
            rd_word[`ASFBL_ST_FRAME_ERR] = s.frame_err;
            rd_word[`ASFBL_ST_PARITY_ERR] = s.parity_err;
            rd_word[`ASFBL_ST_BREAK] = s.break_det;
            rd_word[`ASFBL_ST_RX_ACTIVE] = s.rx_state != ASFBL_RX_IDLE;
        end else if (asfbl_hit(paddr, `ASFBL_IDX_DATA)) begin
            rd_word[8:0] = s.rx_data;
        end else if (asfbl_hit(paddr, `ASFBL_IDX_PORT)) begin
            rd_word[3:0] = s.port;
            rd_word[`ASFBL_PORT_PIN_LO] = s.rxd_sync[1];
            rd_word[`ASFBL_PORT_PIN_LO + 1] = s.txd_sync[1];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_comb begin
        n = s;

        n.txd_sync = {s.txd_sync[0], txd_in};
        n.rxd_sync = {s.rxd_sync[0], rxd_in};

        // bus: read data and error are captured in the setup cycle
        if (setup) begin
            n.prdata = pwrite ? 32'h0000_0000 : rd_word;
            n.pslverr = !rd_hit;
        end

        // rate generator; sticky arm after first enable
        if (s.tx_enable || s.rx_enable) begin
            n.baud_armed = 1'b1; // RL12
        end
        if (!s.baud_armed || s.div[12:0] == 13'h0000 || tick) begin
            n.baud_cnt = 13'h0000; // RL8
        end else begin
            n.baud_cnt = s.baud_cnt + 13'h0001;
        end

        // transmitter
        if (!s.tx_enable) begin
            n.tx_state = ASFBL_TX_IDLE;
            n.tx_sub = 4'h0;
        end else if (tick) begin
            unique case (s.tx_state)
                ASFBL_TX_IDLE: begin
                    n.tx_sub = 4'h0;
                    n.tx_left = frame_bits + 4'd2;
                    if (s.send_break) begin
                        n.tx_sr = 11'h000; // RL5
                        n.tx_state = ASFBL_TX_SHIFT;
                    end else if (!s.tx_ready) begin
                        n.tx_sr = asfbl_frame(s.tx_hold, nine, par_en, par_odd); // RL6
                        n.tx_ready = 1'b1;
                        n.tx_state = ASFBL_TX_SHIFT;
                    end
                end
                ASFBL_TX_SHIFT: begin
                    n.tx_sub = s.tx_sub + 4'h1;
                    if (s.tx_sub == `ASFBL_TICK_LAST) begin
                        n.tx_sr = {1'b1, s.tx_sr[10:1]}; // RL3
                        n.tx_left = s.tx_left - 4'h1;
                        if (s.tx_left == 4'h1) begin
                            n.tx_state = ASFBL_TX_IDLE;
                        end
                    end
                end
            endcase
        end

        // receiver: sixteen ticks per bit, middle sample of each bit
        if (tick) begin
            n.rx_prev = rx_src;
        end
        if (!s.rx_enable) begin
            n.rx_state = ASFBL_RX_IDLE;
        end else if (tick) begin
            unique case (s.rx_state)
                ASFBL_RX_IDLE: begin
                    // needs a high before the low so a held break is taken once
                    if (s.rx_prev && !rx_src) begin
                        n.rx_state = ASFBL_RX_START; // RL1 RL2
                        n.rx_sub = 4'h0;
                    end
                end
                ASFBL_RX_START: begin
                    n.rx_sub = s.rx_sub + 4'h1;
                    if (s.rx_sub == `ASFBL_START_MID) begin
                        // a start bit gone high by mid-bit is a glitch
                        n.rx_state = rx_src ? ASFBL_RX_IDLE : ASFBL_RX_DATA; // RL2
                        n.rx_sub = 4'h0;
                        n.rx_idx = 4'h0;
                        n.rx_sr = 9'h000;
                    end
                end
                ASFBL_RX_DATA: begin
                    n.rx_sub = s.rx_sub + 4'h1;
                    if (s.rx_sub == `ASFBL_TICK_LAST) begin
                        n.rx_sr[s.rx_idx] = rx_src; // RL3
                        n.rx_idx = s.rx_idx + 4'h1;
                        if (s.rx_idx == frame_bits - 4'h1) begin
                            n.rx_state = ASFBL_RX_STOP; // RL7
                        end
                    end
                end
                ASFBL_RX_STOP: begin
                    n.rx_sub = s.rx_sub + 4'h1;
                    if (s.rx_sub == `ASFBL_TICK_LAST) begin
                        n.rx_state = ASFBL_RX_IDLE;
                    end
                end
            endcase
        end

        // register writes and side effects of reads
        if (access && pwrite) begin
            if (asfbl_hit(paddr, `ASFBL_IDX_DIV)) begin
                if (pstrb[1]) begin
                    n.div_hi_stage[4:0] = pwdata[12:8]; // RL11
                    if (special_mode) begin
                        n.div_hi_stage[7:5] = pwdata[15:13]; // RL11
                    end
                end
                if (pstrb[0]) begin
                    n.div = {n.div_hi_stage, pwdata[7:0]}; // RL10
                end
            end
            if (asfbl_hit(paddr, `ASFBL_IDX_CTRL) && pstrb[0]) begin
                n.ctrl = pwdata[7:0];
            end
            if (asfbl_hit(paddr, `ASFBL_IDX_ENA) && pstrb[0]) begin
                n.tx_enable = pwdata[`ASFBL_TX_ENABLE]; // RL20
                n.rx_enable = pwdata[`ASFBL_RX_ENABLE]; // RL20
                n.send_break = pwdata[`ASFBL_SEND_BREAK];
            end
            if (asfbl_hit(paddr, `ASFBL_IDX_DATA) && pstrb[0]) begin
                n.tx_hold = {pstrb[1] ? pwdata[8] : s.tx_hold[8], pwdata[7:0]};
                n.tx_ready = 1'b0;
            end
            if (asfbl_hit(paddr, `ASFBL_IDX_PORT) && pstrb[0]) begin
                n.port = pwdata[3:0];
            end
        end
        if (access && !pwrite && asfbl_hit(paddr, `ASFBL_IDX_DATA)) begin
            n.rx_full = 1'b0;
            n.overrun = 1'b0;
            n.frame_err = 1'b0;
            n.parity_err = 1'b0;
            n.break_det = 1'b0;
        end

        // character completion comes after the clear so a new event is kept
        if (s.rx_enable && tick && s.rx_state == ASFBL_RX_STOP
                && s.rx_sub == `ASFBL_TICK_LAST) begin
            if (s.rx_full) begin
                n.overrun = 1'b1;
            end else begin
                n.rx_full = 1'b1;
                n.rx_data = s.rx_sr;
                n.frame_err = !rx_src; // RL4
                n.break_det = !rx_src && (s.rx_sr == 9'h000); // RL5
                n.parity_err = par_en
                    && ((^(s.rx_sr & asfbl_mask(nine))) != par_odd); // RL6
            end
        end

        // RL1
        n.tx_line = (n.tx_state == ASFBL_TX_SHIFT) ? n.tx_sr[0] : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.ctrl <= `ASFBL_CTRL_RESET;
            s.div <= `ASFBL_DIV_RESET;
            s.port <= `ASFBL_PORT_RESET;
            s.txd_sync <= 2'b11;
            s.rxd_sync <= 2'b11;
            s.tx_ready <= 1'b1;
            s.tx_line <= 1'b1;
            s.rx_prev <= 1'b1;
            s.tx_state <= ASFBL_TX_IDLE;
            s.rx_state <= ASFBL_RX_IDLE;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign pready = 1'b1;

endmodule

// ---- pkg/asfbl_cfg.svh ----
`ifndef ASFBL_CFG_SVH
`define ASFBL_CFG_SVH

// register indices; byte address is four times the index
`define ASFBL_IDX_DIV 8'hC0
`define ASFBL_IDX_CTRL 8'hC2
`define ASFBL_IDX_ENA 8'hC3
`define ASFBL_IDX_STAT 8'hC4
`define ASFBL_IDX_DATA 8'hC7
`define ASFBL_IDX_PORT 8'hC8

`define ASFBL_CTRL_RESET 8'h00
`define ASFBL_DIV_RESET 16'h0000
`define ASFBL_PORT_RESET 4'h0

// frame_loop_control fields
`define ASFBL_LOOP_SELECT 7
`define ASFBL_WIRED_OR_SELECT 6
`define ASFBL_RX_FEEDBACK_SELECT 5
`define ASFBL_NINE_BITS 4
`define ASFBL_PARITY_EN 1
`define ASFBL_PARITY_ODD 0

// enable_control_reg fields
`define ASFBL_TX_ENABLE 3
`define ASFBL_RX_ENABLE 2
`define ASFBL_SEND_BREAK 0

// port register fields
`define ASFBL_PORT_DIR_LO 2
`define ASFBL_PORT_PIN_LO 8

// status register fields
`define ASFBL_ST_TX_READY 0
`define ASFBL_ST_TX_IDLE 1
`define ASFBL_ST_RX_FULL 2
`define ASFBL_ST_OVERRUN 3
`define ASFBL_ST_FRAME_ERR 4
`define ASFBL_ST_PARITY_ERR 5
`define ASFBL_ST_BREAK 6
`define ASFBL_ST_RX_ACTIVE 7

// oversampling: sixteen baud ticks per bit, start verified at tick 8
`define ASFBL_TICK_LAST 4'hF
`define ASFBL_START_MID 4'h7
`define ASFBL_DIV_BITS 13

`endif

// ---- pkg/asfbl_pkg.sv ----
package asfbl_pkg;

    typedef enum logic {
        ASFBL_TX_IDLE,
        ASFBL_TX_SHIFT
    } asfbl_tx_state_t;

    typedef enum logic [1:0] {
        ASFBL_RX_IDLE,
        ASFBL_RX_START,
        ASFBL_RX_DATA,
        ASFBL_RX_STOP
    } asfbl_rx_state_t;

    // serial pin drive; oe_n low while the pin is driven
    typedef struct packed {
        logic txd_out;
        logic txd_oe_n;
        logic rxd_out;
        logic rxd_oe_n;
    } asfbl_pins_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic tx_enable;
        logic rx_enable;
        logic send_break;
        logic [15:0] div;
        logic [7:0] div_hi_stage;
        logic [3:0] port;
        logic baud_armed;
        logic [12:0] baud_cnt;
        logic [1:0] txd_sync;
        logic [1:0] rxd_sync;
        asfbl_tx_state_t tx_state;
        logic [3:0] tx_sub;
        logic [3:0] tx_left;
        logic [10:0] tx_sr;
        logic [8:0] tx_hold;
        logic tx_ready;
        logic tx_line;
        asfbl_rx_state_t rx_state;
        logic [3:0] rx_sub;
        logic [3:0] rx_idx;
        logic [8:0] rx_sr;
        logic rx_prev;
        logic [8:0] rx_data;
        logic rx_full;
        logic overrun;
        logic frame_err;
        logic parity_err;
        logic break_det;
        logic [31:0] prdata;
        logic pslverr;
    } asfbl_state_t;

endpackage

// ---- testbench/asfbl_uart_asserts.sv ----
`timescale 1ns/100ps
module asfbl_uart_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input asfbl_pkg::asfbl_pins_t pins
);
    import asfbl_pkg::*;
    logic [7:0] ctrl;
    logic [7:0] port;
    logic te;
    wire acc = psel && penable;
    // released pin reads high through the line pull-up
    wire line = pins.txd_oe_n | pins.txd_out;
    wire mapped = paddr inside {12'h300, 12'h308, 12'h30C, 12'h310, 12'h31C, 12'h320};
    // shadows of the writable control bits, seen only through bus traffic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 8'h00;
            port <= 8'h00;
            te <= 1'b0;
        end else if (acc && pwrite && pstrb[0]) begin
            if (paddr == 12'h308) ctrl <= pwdata[7:0];
            if (paddr == 12'h320) port <= pwdata[7:0];
            if (paddr == 12'h30C) te <= pwdata[3];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_high_a: assert property (acc |-> pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    ctrl_readback_a: assert property (acc && !pwrite && paddr == 12'h308 |-> prdata[7:0] == ctrl)
        else $error("control register read differs from last write");
    wired_or_a: assert property (ctrl[6] |-> (pins.txd_oe_n | !pins.txd_out) && (pins.rxd_oe_n | !pins.rxd_out))
        else $error("pin driven high in wired-or mode");
    loop_idle_a: assert property (ctrl[7] && !ctrl[5] && !ctrl[6] && !port[3] |-> !pins.txd_oe_n && pins.txd_out)
        else $error("loop pin not held high");
    single_hiz_a: assert property (ctrl[7] && ctrl[5] && !port[3] |-> pins.txd_oe_n)
        else $error("loop pin not released");
    tx_owns_pin_a: assert property (te && !ctrl[7] && !ctrl[6] |-> !pins.txd_oe_n)
        else $error("transmit pin not driven while enabled");
    gpio_release_a: assert property (!te && !ctrl[7] && !port[3] |-> pins.txd_oe_n)
        else $error("transmit pin driven while unused");
    start_bit_a: assert property (te && $fell(line) |-> !line [*8])
        else $error("start bit too short");
    cover property (acc && pslverr);
    cover property (ctrl[7] && $fell(line));
    cover property (ctrl[6] && !pins.txd_oe_n);
endmodule

bind asfbl_uart asfbl_uart_chk i_asfbl_uart_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));

// ---- testbench/asfbl_remote.sv ----
`timescale 1ns/100ps
module asfbl_remote (
    input logic pclk,
    input logic line_in,
    input logic jam,
    output logic line_out
);
    int bc = 32;
    logic drv = 1'b1;
    // jam holds the line low to prove the receiver is detached
    assign line_out = jam ? 1'b0 : drv;
    task automatic send(input int nb, input logic [8:0] d, input logic stop);
        drv <= 1'b0;
        repeat (bc) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            drv <= d[i];
            repeat (bc) @(posedge pclk);
        end
        drv <= stop;
        repeat (bc) @(posedge pclk);
        drv <= 1'b1;
        repeat (bc) @(posedge pclk);
    endtask
    // samples each bit at its middle, so a wrong bit time drifts out
    task automatic grab(input int nb, output logic [8:0] d, output logic stop);
        int n;
        n = 0;
        d = 9'h000;
        while (line_in !== 1'b0 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        repeat (bc / 2) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge pclk);
            d[i] = line_in;
        end
        repeat (bc) @(posedge pclk);
        stop = line_in;
    endtask
endmodule

// ---- testbench/asfbl_tb.sv ----
`timescale 1ns/100ps
`include "asfbl_cfg.svh"
`define CHK(n, s, e) begin check_count++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
    import asfbl_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0, special_mode = 0, jam = 0, saw_low = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, rerr, stp, line, rline, rxd;
    logic [8:0] got, pm, m;
    logic [7:0] c;
    logic [7:0] cf [5] = '{8'h00, 8'h02, 8'h10, 8'h12, 8'h13};
    logic [7:0] lp [3] = '{8'h80, 8'hA0, 8'hE0};
    asfbl_pins_t pins;
    int bad_count = 0, check_count = 0, nb;
    assign line = pins.txd_oe_n | pins.txd_out;
    assign rxd = pins.rxd_oe_n ? rline : pins.rxd_out;
    asfbl_uart i_asfbl_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .special_mode(special_mode), .txd_in(line),
        .rxd_in(rxd), .pins(pins));
    asfbl_remote remote (.pclk(pclk), .line_in(line), .jam(jam), .line_out(rline));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (line === 1'b0) saw_low <= 1'b1;
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
        input logic [3:0] st);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("mismatch pready exp 1 got %0b", pready);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        apb(1'b1, i, d, 4'hF);
    endtask
    task automatic rd(input logic [7:0] i);
        apb(1'b0, i, 32'h0, 4'h0);
    endtask
    // polls status until the given flag rises
    task automatic wrx(input int b);
        int n;
        n = 0;
        rdat = 32'h0;
        while (rdat[b] !== 1'b1 && n < 400) begin
            rd(`ASFBL_IDX_STAT);
            n++;
        end
        // a flag that never rises is a failure even if later checks happen to agree
        if (rdat[b] !== 1'b1) begin
            bad_count++;
            $display("mismatch poll exp 1 got %0b", rdat[b]);
        end
    endtask
    function automatic logic [8:0] frm(input logic [7:0] f, input logic [8:0] d);
        int n;
        n = f[4] ? 9 : 8;
        if (!f[4]) d[8] = 1'b0;
        if (f[1]) begin
            d[n-1] = f[0];
            for (int i = 0; i < n - 1; i++) d[n-1] ^= d[i];
        end
        return d;
    endfunction
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        // the whole run needs about ten thousand cycles; allow three times that
        #300000;
        bad_count++;
        $display("mismatch watchdog exp done got timeout");
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("idle", line, 1'b1)
        rd(`ASFBL_IDX_CTRL);
        `CHK("ctrl", rdat, 32'h0)
        wr(8'hC1, 32'hFF);
        `CHK("slverr", rerr, 1'b1)
        apb(1'b1, `ASFBL_IDX_DIV, 32'h0100, 4'h2);
        rd(`ASFBL_IDX_DIV);
        `CHK("div_hi", rdat, 32'h0)
        apb(1'b1, `ASFBL_IDX_DIV, 32'h0002, 4'h1);
        rd(`ASFBL_IDX_DIV);
        `CHK("div_lo", rdat, 32'h0102)
        wr(`ASFBL_IDX_DIV, 32'hE003);
        rd(`ASFBL_IDX_DIV);
        `CHK("div_top", rdat, 32'h0003)
        special_mode <= 1'b1;
        wr(`ASFBL_IDX_DIV, 32'hE000);
        rd(`ASFBL_IDX_DIV);
        `CHK("div_spec", rdat, 32'hE000)
        special_mode <= 1'b0;
        done("regs");
        wr(`ASFBL_IDX_ENA, 32'h0C);
        wr(`ASFBL_IDX_DATA, 32'h55);
        saw_low <= 1'b0;
        repeat (300) @(posedge pclk);
        `CHK("no_tick", saw_low, 1'b0)
        fork
            remote.grab(8, got, stp);
            wr(`ASFBL_IDX_DIV, 32'h0002);
        join
        `CHK("rate", got, 9'h055)
        `CHK("stop", stp, 1'b1)
        done("rate");
        foreach (cf[k]) begin
            c = cf[k];
            nb = c[4] ? 9 : 8;
            pm = c[1] ? (c[4] ? 9'h100 : 9'h080) : 9'h000;
            m = (c[4] ? 9'h1FF : 9'h0FF) & ~pm;
            wr(`ASFBL_IDX_CTRL, {24'h0, c});
            fork
                remote.grab(nb, got, stp);
                wr(`ASFBL_IDX_DATA, 32'h1A5);
            join
            `CHK("tx_frame", got, frm(c, 9'h1A5))
            for (int b = 0; b < 2; b++) begin
                remote.send(nb, frm(c, 9'h1A5) ^ (b ? pm : 9'h000), 1'b1);
                wrx(2);
                `CHK("perr", rdat[5], b ? c[1] : 1'b0)
                rd(`ASFBL_IDX_DATA);
                `CHK("rx", rdat[8:0] & m, frm(c, 9'h1A5) & m)
            end
        end
        done("format");
        wr(`ASFBL_IDX_CTRL, 32'h0);
        remote.send(8, 9'h000, 1'b0);
        wrx(6);
        `CHK("rx_break", rdat[6:4], 3'b101)
        rd(`ASFBL_IDX_DATA);
        fork
            remote.grab(8, got, stp);
            wr(`ASFBL_IDX_ENA, 32'h0D);
        join
        wr(`ASFBL_IDX_ENA, 32'h0C);
        `CHK("tx_break", {stp, got}, 10'h000)
        repeat (800) @(posedge pclk);
        done("break");
        wr(`ASFBL_IDX_CTRL, 32'h80);
        jam <= 1'b1;
        saw_low <= 1'b0;
        wr(`ASFBL_IDX_DATA, 32'h96);
        wrx(2);
        `CHK("pin_high", saw_low, 1'b0)
        rd(`ASFBL_IDX_DATA);
        `CHK("loop_rx", rdat[8:0], 9'h096)
        wr(`ASFBL_IDX_CTRL, 32'hA0);
        `CHK("hiz", pins.txd_oe_n, 1'b1)
        wr(`ASFBL_IDX_PORT, 32'h0D);
        `CHK("rx_gpio", {pins.rxd_oe_n, pins.rxd_out}, 2'b01)
        foreach (lp[k]) begin
            wr(`ASFBL_IDX_CTRL, {24'h0, lp[k]});
            fork
                remote.grab(8, got, stp);
                wr(`ASFBL_IDX_DATA, 32'h3C);
            join
            `CHK("pin_tx", got, 9'h03C)
            wrx(2);
            rd(`ASFBL_IDX_DATA);
            `CHK("wire_rx", rdat[8:0], 9'h03C)
        end
        jam <= 1'b0;
        done("loop");
        give_verdict();
    end
endmodule
